// ---- hdl/mcel_error_logger.sv ----
// Memory controller and link machine-check error logger, register port and banks
`default_nettype none

module mcel_error_logger #(
    parameter int NUM_MEM_BANKS = mcel_pkg::MCEL_NUM_MEM_BANKS  // Memory banks in the group
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire mcel_pkg::mcel_msr_req_t    msr_req,
    input  wire mcel_pkg::mcel_mem_event_t  mem_evt,
    input  wire mcel_pkg::mcel_link_event_t link_evt,
    output var  mcel_pkg::mcel_msr_rsp_t    msr_rsp
);

    // ------------------------------------------------------------
    // Overview
    // ------------------------------------------------------------
    // Software reaches every register through one request port.
    // A request is taken in the cycle its valid bit is high.
    // The answer comes one cycle later and stands one cycle.
    // Link faults land in the link bank only.
    // Memory faults land in the memory bank picked by the bank
    // field, in none if no such bank exists, never in the link bank.
    // The control register steers how much a memory bank logs.

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------

    // Only the extra-logging enable is implemented
    logic [63:0] ctrl_reg;

    // Extra logging enable, taken from the control register
    logic ext_log_en;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------

    // Offset of the index from the memory bank base
    logic [7:0] mem_off;

    // Bank number and register select within the bank
    logic [6:0] mem_bank_sel;
    logic       mem_misc_sel;

    // Index falls in the control register
    logic hit_ctrl;

    // Index falls in the link status register
    logic hit_link;

    // Index falls in the memory bank range
    logic hit_mem;

    // Index maps to some register
    logic hit_any;

    // Write strobes, one cycle each
    logic wr_ctrl;
    logic wr_link;

    // ------------------------------------------------------------
    // Bank outputs
    // ------------------------------------------------------------

    // Link bank status
    logic [63:0] link_status;

    // Memory bank status and misc, one word each
    logic [63:0] mem_status [NUM_MEM_BANKS];
    logic [63:0] mem_misc   [NUM_MEM_BANKS];

    // Read data chosen from the decoded register
    logic [63:0] rd_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------

    // Extra logging follows control bit 1
    assign ext_log_en = ctrl_reg[mcel_pkg::MCEL_CTRL_EXT_LOG_BIT];

    // Distance from the first memory bank register
    assign mem_off = msr_req.index - mcel_pkg::MCEL_IDX_MEM_BASE;

    // Two registers per bank: even is status, odd is misc
    assign mem_bank_sel = mem_off[7:1];
    assign mem_misc_sel = mem_off[0];

    // Control register match
    assign hit_ctrl = (msr_req.index == mcel_pkg::MCEL_IDX_CTRL);

    // Link status match
    assign hit_link = (msr_req.index == mcel_pkg::MCEL_IDX_LINK_STATUS);

    // Memory range match; below the base wraps high and misses
    assign hit_mem = (msr_req.index >= mcel_pkg::MCEL_IDX_MEM_BASE) &&
                     (32'(mem_bank_sel) < 32'(NUM_MEM_BANKS));

    // Any known register
    assign hit_any = hit_ctrl || hit_link || hit_mem;

    // Write strobes for the registers held here and in the link bank
    assign wr_ctrl = msr_req.valid && msr_req.write && hit_ctrl;
    assign wr_link = msr_req.valid && msr_req.write && hit_link;

    // ------------------------------------------------------------
    // Control register update
    // ------------------------------------------------------------

    // Only bit 1 is writable; the others read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Extra logging off after reset
            ctrl_reg <= mcel_pkg::MCEL_REG_RESET;
        end else if (wr_ctrl) begin
            // Keep the enable bit, drop the rest
            ctrl_reg <= mcel_pkg::MCEL_REG_RESET;
            ctrl_reg[mcel_pkg::MCEL_CTRL_EXT_LOG_BIT] <=
                msr_req.wdata[mcel_pkg::MCEL_CTRL_EXT_LOG_BIT];
        end
    end

    // ------------------------------------------------------------
    // Link error bank
    // ------------------------------------------------------------

    // Link faults never touch the memory banks
    mcel_link_bank i_mcel_link_bank (
        .clk        (clk),
        .rst        (rst),
        .evt        (link_evt),
        .wr_status  (wr_link),
        .wdata      (msr_req.wdata),
        .status_reg (link_status)
    );

    // ------------------------------------------------------------
    // Memory controller error banks
    // ------------------------------------------------------------

    // One bank per memory channel group, separate from the link bank
    generate
        for (genvar b = 0; b < NUM_MEM_BANKS; b++) begin : g_mem_bank
            // This bank's own fault strobe
            logic evt_hit;

            // This bank's register write strobes
            logic wr_status;
            logic wr_misc;

            // Fault report addressed to this bank
            assign evt_hit = mem_evt.valid &&
                             (32'(mem_evt.bank) == b);

            // Status write: even register of this bank
            assign wr_status = msr_req.valid && msr_req.write && hit_mem &&
                               (32'(mem_bank_sel) == b) && !mem_misc_sel;

            // Misc write: odd register of this bank
            assign wr_misc = msr_req.valid && msr_req.write && hit_mem &&
                             (32'(mem_bank_sel) == b) && mem_misc_sel;

            // Bank logic
            mcel_mem_bank i_mcel_mem_bank (
                .clk        (clk),
                .rst        (rst),
                .ext_log_en (ext_log_en),
                .evt        (mem_evt),
                .evt_hit    (evt_hit),
                .wr_status  (wr_status),
                .wr_misc    (wr_misc),
                .wdata      (msr_req.wdata),
                .status_reg (mem_status[b]),
                .misc_reg   (mem_misc[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------

    // Pick the addressed register; unmapped reads give zero
    always_comb begin
        rd_next = mcel_pkg::MCEL_REG_RESET;
        if (hit_ctrl) begin
            // Control register
            rd_next = ctrl_reg;
        end else if (hit_link) begin
            // Link status
            rd_next = link_status;
        end else if (hit_mem) begin
            // Memory bank status or misc
            for (int i = 0; i < NUM_MEM_BANKS; i++) begin
                if (32'(mem_bank_sel) == i) begin
                    rd_next = mem_misc_sel ? mem_misc[i] : mem_status[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------

    // Acknowledge every request a cycle later, flag unmapped ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Idle answer
            msr_rsp.ack   <= 1'b0;
            msr_rsp.err   <= 1'b0;
            msr_rsp.rdata <= mcel_pkg::MCEL_REG_RESET;
        end else begin
            // Pulse for one cycle per request
            msr_rsp.ack <= msr_req.valid;
            // Error only on an accepted request to no register
            msr_rsp.err <= msr_req.valid && !hit_any;
            if (msr_req.valid && !msr_req.write) begin
                // Read data for a read
                msr_rsp.rdata <= rd_next;
            end else begin
                // Writes and idle cycles return zero
                msr_rsp.rdata <= mcel_pkg::MCEL_REG_RESET;
            end
        end
    end

    // ------------------------------------------------------------
    // Notes for users
    // ------------------------------------------------------------
    // A fault report and a write to the same bank register in
    // one cycle: the fault wins and the write is lost, so a
    // clear never swallows a new fault.
    // Once both device slots of a bank are valid, further
    // corrected reads only refresh the status word; software
    // clears misc to open the slots again.
    // Turning extra logging off wipes the device masks, ranks and
    // valid bits on the next edge, but misc 13:9 keeps its value;
    // turning it back on starts from empty slots.
    // The second slot is meaningful only with bit 63 set.

endmodule : mcel_error_logger

`default_nettype wire

// ---- hdl/mcel_link_bank.sv ----
// One link error bank: status with the bus-format compound code
`default_nettype none

module mcel_link_bank (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire mcel_pkg::mcel_link_event_t evt,
    input  wire logic                       wr_status,
    input  wire logic [63:0]                wdata,
    output var  logic [63:0]                status_reg
);

    // Event overwrites the code; an event beats a write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_reg <= mcel_pkg::MCEL_REG_RESET;
        end else if (evt.valid) begin
            // Pattern 1PPTRRRRIILL in bits 11:0, upper bits zero
            status_reg <= {48'h0000_0000_0000, 4'h0, 1'b1, evt.participation, evt.timeout,
                           evt.request, evt.mem_io, evt.level};
        end else if (wr_status) begin
            // Software may rewrite or clear the code
            status_reg <= wdata & mcel_pkg::MCEL_LINK_STATUS_WMASK;
        end
    end

endmodule : mcel_link_bank

`default_nettype wire

// ---- hdl/mcel_mem_bank.sv ----
// One memory controller error bank: status and miscellaneous registers
`default_nettype none

module mcel_mem_bank (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ext_log_en,
    input  wire mcel_pkg::mcel_mem_event_t evt,
    input  wire logic                      evt_hit,
    input  wire logic                      wr_status,
    input  wire logic                      wr_misc,
    input  wire logic [63:0]               wdata,
    output var  logic [63:0]               status_reg,
    output var  logic [63:0]               misc_reg
);

    logic        corr_read;  // Corrected error seen on a normal read
    logic        par_wr;     // Write-buffer data or byte-enable parity
    logic [63:0] misc_next;  // Miscellaneous value before the clear

    assign corr_read = (evt.kind == mcel_pkg::MCEL_K_CORR_READ);
    assign par_wr    = (evt.kind == mcel_pkg::MCEL_K_WB_DATA_PARITY) ||
                       (evt.kind == mcel_pkg::MCEL_K_BE_PARITY);

    // Status capture; an event beats a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_reg <= mcel_pkg::MCEL_REG_RESET;
        end else if (evt_hit) begin
            status_reg <= mcel_pkg::MCEL_REG_RESET;
            // Memory format 0000 0000 1MMM CCCC
            status_reg[15:0] <= {8'h00, 1'b1, evt.txn, evt.channel};
            status_reg[31:16] <= mcel_pkg::mcel_model_code(evt.kind);
            if (ext_log_en && corr_read) begin
                status_reg[36:32] <= evt.dev_info;
            end
        end else if (wr_status) begin
            status_reg <= wdata & mcel_pkg::MCEL_MEM_STATUS_WMASK;
        end
    end

    // Next miscellaneous value, first device slot before second
    always_comb begin
        misc_next = misc_reg;
        if (evt_hit) begin
            if (ext_log_en && corr_read) begin
                if (!misc_reg[mcel_pkg::MCEL_VALID1_BIT]) begin
                    misc_next[29:14] = evt.mask;
                    misc_next[50:46] = evt.rank;
                    misc_next[mcel_pkg::MCEL_VALID1_BIT] = 1'b1;
                end else if (!misc_reg[mcel_pkg::MCEL_VALID2_BIT]) begin
                    // Second slot only fills after the first is valid
                    misc_next[13:9] = evt.dev_info;
                    misc_next[45:30] = evt.mask;
                    misc_next[55:51] = evt.rank;
                    misc_next[mcel_pkg::MCEL_VALID2_BIT] = 1'b1;
                end
            end else if (!ext_log_en && par_wr) begin
                misc_next[13:9] = evt.parity_info;
            end
        end else if (wr_misc) begin
            misc_next = wdata & mcel_pkg::MCEL_MISC_WMASK;
        end
    end

    // Misc register; extra fields forced clear while logging is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            misc_reg <= mcel_pkg::MCEL_REG_RESET;
        end else if (!ext_log_en) begin
            misc_reg <= misc_next & ~mcel_pkg::MCEL_MISC_EXT_FIELDS;
        end else begin
            misc_reg <= misc_next;
        end
    end

endmodule : mcel_mem_bank

`default_nettype wire

// ---- include/mcel_pkg.sv ----
// Shared types, field layouts and register indices of the memory error logger
// Behaviour
// - Link status bits 15:0 hold bus-format code
// - Memory errors use their own bank group
// - Memory code is one, transaction, then channel
// - Control bit 1 enables extra memory logging
// - Parity faults coded 001H, 002H, 004H
// - Scrub/spare faults coded 008H to 040H
// - Status 36:32 keep first device info
// - Misc 13:9 keep second device info
// - Otherwise misc 13:9 keep parity info
// - Misc 29:14 keep first device mask
// - Misc 45:30 keep second device mask
// - Misc 50:46 keep first failing rank
// - Misc 55:51 keep second failing rank
// - Misc bit 62 flags first device logged
// - Misc bit 63 flags second device logged
`default_nettype none

package mcel_pkg;

    // Register indices on the model-specific register port
    localparam logic [7:0] MCEL_IDX_CTRL        = 8'h00;
    localparam logic [7:0] MCEL_IDX_LINK_STATUS = 8'h01;
    localparam logic [7:0] MCEL_IDX_MEM_BASE    = 8'h10;
    localparam int         MCEL_NUM_MEM_BANKS   = 4;
    localparam int         MCEL_BANK_IDX_W      = 3;

    // Reset values
    localparam logic [63:0] MCEL_REG_RESET = 64'h0000_0000_0000_0000;

    // Control register field
    localparam int MCEL_CTRL_EXT_LOG_BIT = 1;

    // Status register fields
    localparam int MCEL_CODE_LSB       = 0;
    localparam int MCEL_MODEL_LSB      = 16;
    localparam int MCEL_FIRST_INFO_LSB = 32;
    localparam logic [63:0] MCEL_LINK_STATUS_WMASK = 64'h0000_0000_0000_FFFF;
    localparam logic [63:0] MCEL_MEM_STATUS_WMASK  = 64'h0000_001F_FFFF_FFFF;

    // Miscellaneous register fields
    localparam int MCEL_SECOND_INFO_LSB = 9;
    localparam int MCEL_MASK1_LSB       = 14;
    localparam int MCEL_MASK2_LSB       = 30;
    localparam int MCEL_RANK1_LSB       = 46;
    localparam int MCEL_RANK2_LSB       = 51;
    localparam int MCEL_VALID1_BIT      = 62;
    localparam int MCEL_VALID2_BIT      = 63;
    localparam logic [63:0] MCEL_MISC_WMASK      = 64'hC0FF_FFFF_FFFF_FE00;
    localparam logic [63:0] MCEL_MISC_EXT_FIELDS = 64'hC0FF_FFFF_FFFF_C000;

    // Model-specific error codes of the memory banks
    localparam logic [15:0] MCEL_MC_ADDR_PARITY  = 16'h0001;
    localparam logic [15:0] MCEL_MC_WB_PARITY    = 16'h0002;
    localparam logic [15:0] MCEL_MC_BE_PARITY    = 16'h0004;
    localparam logic [15:0] MCEL_MC_CORR_SCRUB   = 16'h0008;
    localparam logic [15:0] MCEL_MC_UNCORR_SCRUB = 16'h0010;
    localparam logic [15:0] MCEL_MC_CORR_SPARE   = 16'h0020;
    localparam logic [15:0] MCEL_MC_UNCORR_SPARE = 16'h0040;
    localparam logic [15:0] MCEL_MC_NONE         = 16'h0000;

    // Kinds of memory controller fault
    typedef enum logic [2:0] {
        MCEL_K_ADDR_PARITY,
        MCEL_K_WB_DATA_PARITY,
        MCEL_K_BE_PARITY,
        MCEL_K_CORR_SCRUB,
        MCEL_K_UNCORR_SCRUB,
        MCEL_K_CORR_SPARE,
        MCEL_K_UNCORR_SPARE,
        MCEL_K_CORR_READ
    } mcel_mem_kind_t;

    // One memory controller fault report
    typedef struct packed {
        logic                       valid;
        logic [MCEL_BANK_IDX_W-1:0] bank;
        mcel_mem_kind_t             kind;
        logic [2:0]                 txn;
        logic [3:0]                 channel;
        logic [4:0]                 dev_info;
        logic [15:0]                mask;
        logic [4:0]                 rank;
        logic [4:0]                 parity_info;
    } mcel_mem_event_t;

    // One link fault report, bus-error subfields
    typedef struct packed {
        logic       valid;
        logic [1:0] participation;
        logic       timeout;
        logic [3:0] request;
        logic [1:0] mem_io;
        logic [1:0] level;
    } mcel_link_event_t;

    // Register port request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  index;
        logic [63:0] wdata;
    } mcel_msr_req_t;

    // Register port answer
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [63:0] rdata;
    } mcel_msr_rsp_t;

    // Model-specific code for a fault kind
    function automatic logic [15:0] mcel_model_code(input mcel_mem_kind_t kind);
        unique case (kind)
            MCEL_K_ADDR_PARITY:    return MCEL_MC_ADDR_PARITY;
            MCEL_K_WB_DATA_PARITY: return MCEL_MC_WB_PARITY;
            MCEL_K_BE_PARITY:      return MCEL_MC_BE_PARITY;
            MCEL_K_CORR_SCRUB:     return MCEL_MC_CORR_SCRUB;
            MCEL_K_UNCORR_SCRUB:   return MCEL_MC_UNCORR_SCRUB;
            MCEL_K_CORR_SPARE:     return MCEL_MC_CORR_SPARE;
            MCEL_K_UNCORR_SPARE:   return MCEL_MC_UNCORR_SPARE;
            MCEL_K_CORR_READ:      return MCEL_MC_NONE;
        endcase
    endfunction : mcel_model_code

endpackage : mcel_pkg

`default_nettype wire

// ---- test/mcel_error_logger_asserts.sv ----
// Checker of the error logger register port and logged fields
`default_nettype none

module mcel_error_logger_asserts #(
    parameter int NUM_MEM_BANKS = 4  // Memory banks in the group
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire mcel_pkg::mcel_msr_req_t    msr_req,
    input wire mcel_pkg::mcel_mem_event_t  mem_evt,
    input wire mcel_pkg::mcel_link_event_t link_evt,
    input wire mcel_pkg::mcel_msr_rsp_t    msr_rsp
);
    timeunit 1ns;
    timeprecision 1ns;

    logic ext_q;  // Mirror of the extra logging enable
    logic ext_d;  // Same enable one cycle older
    logic rd_q;   // A read request this cycle

    assign rd_q = msr_req.valid && !msr_req.write;

    // Index decode of the register port
    function automatic logic mapped(input logic [7:0] i);
        return i == 8'h00 || i == 8'h01 || (i >= 8'h10 && int'(i) < 16 + 2 * NUM_MEM_BANKS);
    endfunction : mapped

    // Follow control writes so the enable is known here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_q <= 1'b0;
            ext_d <= 1'b0;
        end else begin
            ext_d <= ext_q;
            if (msr_req.valid && msr_req.write && msr_req.index == 8'h00) begin
                ext_q <= msr_req.wdata[1];
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Fault or control write, a quiet cycle, then a read of the logged register
    sequence s_link_rd;
        link_evt.valid ##1 (!link_evt.valid && !msr_req.valid) ##1 (!link_evt.valid && rd_q && msr_req.index == 8'h01);
    endsequence
    sequence s_mem_rd;
        mem_evt.valid && mem_evt.bank == 3'h0 ##1 (!mem_evt.valid && !msr_req.valid)
            ##1 (!mem_evt.valid && rd_q && msr_req.index == 8'h10);
    endsequence
    sequence s_ctrl_rd;
        msr_req.valid && msr_req.write && msr_req.index == 8'h00 ##1 !msr_req.valid ##1 (rd_q && msr_req.index == 8'h00);
    endsequence

    chk_ack_and_err: assert property (
        msr_req.valid |=> msr_rsp.ack && msr_rsp.err == !mapped($past(msr_req.index))) else $error("bad ack or err");
    chk_ack_single: assert property (
        !msr_req.valid |=> !msr_rsp.ack && !msr_rsp.err) else $error("answer without request");
    chk_rdata_idle: assert property (!rd_q |=> msr_rsp.rdata == 64'h0) else $error("read data outside read");
    chk_unmapped_zero: assert property (
        rd_q && !mapped(msr_req.index) |=> msr_rsp.rdata == 64'h0) else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (
        s_ctrl_rd |=> msr_rsp.rdata == {62'h0, $past(msr_req.wdata[1], 3), 1'b0}) else $error("control readback");
    chk_link_code: assert property (
        s_link_rd |=> msr_rsp.rdata == {52'h0, 1'b1, $past(link_evt[10:0], 3)}) else $error("link code wrong");
    chk_mem_code: assert property (
        s_mem_rd |=> msr_rsp.rdata[15:0] == {8'h00, 1'b1, $past(mem_evt.txn, 3), $past(mem_evt.channel, 3)}
            && msr_rsp.rdata[63:37] == 27'h0) else $error("memory code wrong");
    chk_model_code: assert property (s_mem_rd |=> msr_rsp.rdata[31:16] ==
        ($past(mem_evt.kind, 3) == mcel_pkg::MCEL_K_CORR_READ ? 16'h0000 : 16'h0001 << $past(mem_evt.kind, 3)))
        else $error("model code wrong");
    chk_first_info: assert property (s_mem_rd |=> msr_rsp.rdata[36:32] ==
        ($past(ext_q, 3) && $past(mem_evt.kind, 3) == mcel_pkg::MCEL_K_CORR_READ ? $past(mem_evt.dev_info, 3) : 5'h00))
        else $error("first device info wrong");
    chk_ext_clear: assert property (
        rd_q && msr_req.index == 8'h11 && !ext_q && !ext_d |=> (msr_rsp.rdata & mcel_pkg::MCEL_MISC_EXT_FIELDS) == 64'h0)
        else $error("extra fields set while off");

endmodule : mcel_error_logger_asserts

bind mcel_error_logger mcel_error_logger_asserts #(.NUM_MEM_BANKS(NUM_MEM_BANKS)) i_mcel_error_logger_asserts (
    .clk(clk), .rst(rst), .msr_req(msr_req), .mem_evt(mem_evt), .link_evt(link_evt), .msr_rsp(msr_rsp));

`default_nettype wire

// ---- test/tb_mcel_error_logger.sv ----
// Self-checking bench of the memory and link error logger
`default_nettype none

module tb_mcel_error_logger;
    timeunit 1ns;
    timeprecision 1ns;

    logic                       clk;         // Core clock
    logic                       rst;         // Reset, active high
    mcel_pkg::mcel_msr_req_t    msr_req;     // Register port request
    mcel_pkg::mcel_mem_event_t  mem_evt;     // Memory fault report
    mcel_pkg::mcel_link_event_t link_evt;    // Link fault report
    mcel_pkg::mcel_msr_rsp_t    msr_rsp;     // Register port answer
    mcel_pkg::mcel_msr_rsp_t    rsp;         // Last answer taken
    int                         mismatches;  // Failed comparisons
    int                         n_compared;  // Comparisons made
    logic [63:0]                exp_misc;    // Expected misc of bank 0

    mcel_error_logger i_mcel_error_logger (.clk(clk), .rst(rst), .msr_req(msr_req), .mem_evt(mem_evt),
        .link_evt(link_evt), .msr_rsp(msr_rsp));

    // Clock of 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare one value and count it
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Print the verdict and stop
    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // One register access; the answer is taken mid-cycle after the ack edge
    task automatic access(input logic wr, input logic [7:0] idx, input logic [63:0] wd, input logic err_exp);
        @(posedge clk);
        msr_req <= {1'b1, wr, idx, wd};
        @(posedge clk);
        msr_req.valid <= 1'b0;
        @(negedge clk);
        rsp = msr_rsp;
        check($sformatf("ack err %h", idx), {62'h0, rsp.ack, rsp.err}, {62'h0, 1'b1, err_exp});
    endtask : access

    // Read a register and compare its data
    task automatic rd(input logic [7:0] idx, input logic [63:0] exp);
        access(1'b0, idx, 64'h0, 1'b0);
        check($sformatf("register %h", idx), rsp.rdata, exp);
    endtask : rd

    // Report one memory fault; transaction 5, channel C, parity info 13
    task automatic mem(input logic [2:0] b, input mcel_pkg::mcel_mem_kind_t k, input logic [4:0] dev,
                       input logic [15:0] m, input logic [4:0] rk);
        @(posedge clk);
        mem_evt <= {1'b1, b, k, 3'h5, 4'hC, dev, m, rk, 5'h13};
        @(posedge clk);
        mem_evt.valid <= 1'b0;
    endtask : mem

    // Expected memory status for a fault kind
    function automatic logic [63:0] st_exp(input int k, input logic [4:0] dev);
        return {27'h0, dev, (k == 7) ? 16'h0000 : 16'h0001 << k, 16'h00DC};
    endfunction : st_exp

    // Watchdog against a hung port
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        msr_req = '0;
        mem_evt = '0;
        link_evt = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 64'h0);
        rd(8'h11, 64'h0);
        access(1'b0, 8'h02, 64'h0, 1'b1);
        access(1'b1, 8'h00, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
        rd(8'h00, 64'h2);
        access(1'b1, 8'h00, 64'h0, 1'b0);
        // Link fault in bus format
        @(posedge clk);
        link_evt <= 12'hDA7;
        @(posedge clk);
        link_evt.valid <= 1'b0;
        rd(8'h01, 64'h0DA7);
        // Every model code, spread over the banks, extra logging off
        for (int k = 0; k < 7; k++) begin
            mem(3'(k % 4), mcel_pkg::mcel_mem_kind_t'(k), 5'h1F, 16'hFFFF, 5'h1F);
            rd(8'(16 + 2 * (k % 4)), st_exp(k, 5'h00));
        end
        rd(8'h13, 64'h0000_0000_0000_2600);
        rd(8'h15, 64'h0000_0000_0000_2600);
        rd(8'h17, 64'h0);
        rd(8'h01, 64'h0DA7);
        // Corrected reads with extra logging on
        access(1'b1, 8'h00, 64'h2, 1'b0);
        mem(3'h0, mcel_pkg::MCEL_K_CORR_READ, 5'h05, 16'hA5A5, 5'h03);
        rd(8'h10, st_exp(7, 5'h05));
        exp_misc = 64'h0;
        exp_misc[62] = 1'b1;
        exp_misc[50:46] = 5'h03;
        exp_misc[29:14] = 16'hA5A5;
        rd(8'h11, exp_misc);
        mem(3'h0, mcel_pkg::MCEL_K_CORR_READ, 5'h09, 16'h5A5A, 5'h11);
        exp_misc[63] = 1'b1;
        exp_misc[55:51] = 5'h11;
        exp_misc[45:30] = 16'h5A5A;
        exp_misc[13:9] = 5'h09;
        rd(8'h11, exp_misc);
        mem(3'h0, mcel_pkg::MCEL_K_CORR_READ, 5'h1E, 16'hFFFF, 5'h1F);
        rd(8'h10, st_exp(7, 5'h1E));
        rd(8'h11, exp_misc);
        // Logging off again, then a fault for a bank that does not exist
        access(1'b1, 8'h00, 64'h0, 1'b0);
        rd(8'h11, 64'h0000_0000_0000_1200);
        mem(3'h4, mcel_pkg::MCEL_K_ADDR_PARITY, 5'h00, 16'h0000, 5'h00);
        rd(8'h10, st_exp(7, 5'h1E));
        access(1'b1, 8'h10, 64'h0, 1'b0);
        rd(8'h10, 64'h0);
        give_verdict();
    end

endmodule : tb_mcel_error_logger

`default_nettype wire
